// ==== design/pam_pin_mux.sv ====
// Pin alternate-function mux for ports A and B with its APB register slave.
// How it works
// - pin n field at bits 2n+1:2n.
// - code 00 connects pin to GPIO.
// - listed nonzero code routes pin to its peripheral, unlisted code releases it.
// - port A select at 0x38, resets zero.
// - port B select at 0x3C, resets zero.
// - port A pins 15 and 14 routing.
// - port A pins 13 and 12 routing.
// - port A pins 11 and 10 routing.
// - port A pins 9 and 8 routing.
// - port A pins 7 and 6 routing.
// - port A pin 5 routing, pin 4 GPIO only.
// - port A pins 3 and 2 routing.
// - port A pins 1 and 0 routing.
// - port B pins 15 and 14 routing.
// - port B pins 13 and 12 routing.
// - port B pins 11 and 10 routing.
// - port B pins 9 and 8 routing.
// - port B pins 7 to 4 audio serial.
// - port B pins 3 to 0 sync port 1.
`timescale 1ns/1ps

module pam_pin_mux
	import pam_pkg::*;
(
	// Clock and reset.
	input  wire logic                             clk_i,
	input  wire logic                             rstn_i,

	// APB slave port.
	input  wire logic                             psel_i,
	input  wire logic                             penable_i,
	input  wire logic                             pwrite_i,
	input  wire logic [pam_pkg::PAM_ADDR_W-1:0]   paddr_i,
	input  wire logic [31:0]                      pwdata_i,
	input  wire logic [3:0]                       pstrb_i,
	output logic      [31:0]                      prdata_o,
	output logic                                  pready_o,
	output logic                                  pslverr_o,

	// Pads, pin n of port A is bit n, pin n of port B is bit 16+n.
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] pad_in_i,
	output logic      [pam_pkg::PAM_NUM_PINS-1:0] pad_out_o,
	output logic      [pam_pkg::PAM_NUM_PINS-1:0] pad_oe_o,

	// General-purpose I/O logic side.
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_out_i,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_oe_i,
	output logic      [pam_pkg::PAM_NUM_PINS-1:0] gpio_in_o,
	output logic      [pam_pkg::PAM_NUM_PINS-1:0] gpio_owned_o,

	// Peripheral side, indexed by peripheral signal identifier.
	input  wire logic [pam_pkg::PAM_NUM_SIG-1:0]  periph_out_i,
	input  wire logic [pam_pkg::PAM_NUM_SIG-1:0]  periph_oe_i,
	output logic      [pam_pkg::PAM_NUM_SIG-1:0]  periph_in_o
);

	import pam_pkg::*;

	// Data flow in brief.
	// Software writes two select registers.
	// Each pin looks up its 2-bit field in a table.
	// Code 00 gives the pin to the GPIO logic.
	// A listed code gives it to one peripheral.
	// An unlisted code releases the pin.
	// Pad outputs are combinational, no added delay.
	// Pad inputs pass two sync flops and a register.
	// Port A pin n is pad bit n, port B pin n bit 16+n.
	// Peripheral vectors are indexed by signal id.
	// Id zero is no signal and always reads zero.
	// Crystal signals are routed like any other.
	// Writes are not locked; any write acts at once.
	// Software must not route one signal to two pins.

	// Port A select register, one 2-bit field per pin.
	logic [31:0]             port_a_sel_reg;
	// Port B select register, one 2-bit field per pin.
	logic [31:0]             port_b_sel_reg;
	// Pad levels after the two-flop synchroniser.
	logic [PAM_NUM_PINS-1:0] pad_sync;
	// Each _next vector is this cycle's table lookup.
	// Each _reg vector holds it and drives a port.
	// Next and registered values of what the GPIO logic sees.
	logic [PAM_NUM_PINS-1:0] gpio_in_next;
	logic [PAM_NUM_PINS-1:0] gpio_in_reg;
	// Next and registered ownership flags.
	logic [PAM_NUM_PINS-1:0] gpio_owned_next;
	logic [PAM_NUM_PINS-1:0] gpio_owned_reg;
	// Next and registered values of what the peripherals see.
	logic [PAM_NUM_SIG-1:0]  periph_in_next;
	logic [PAM_NUM_SIG-1:0]  periph_in_reg;
	// Shared decode keeps write, error and read
	// consistent with each other.
	// Decoded APB access phase.
	logic                    apb_access;
	// Address hits on the two select registers.
	logic                    hit_a;
	logic                    hit_b;

	// Returns the 2-bit select code of pin 0..31 from both registers.
	// Port B sits above port A in one 64-bit view.
	// One indexing rule then serves all 32 pins.
	function automatic logic [1:0] pam_pin_code(
		input logic [31:0] sel_a,
		input logic [31:0] sel_b,
		input int          pin
	);
		logic [63:0] sel_all;
		sel_all = {sel_b, sel_a};
		return sel_all[PAM_FIELD_W*pin +: PAM_FIELD_W];
	endfunction

	// Returns the peripheral signal that a pin's current code routes to.
	// The tables live in the package, written once.
	// PAM_SIG_NONE marks a code with no function.
	// Code 00 also maps to it; callers test 00 first.
	function automatic pam_sig_t pam_pin_sig(
		input logic [31:0] sel_a,
		input logic [31:0] sel_b,
		input int          pin
	);
		logic [1:0] code;
		code = pam_pin_code(sel_a, sel_b, pin);
		if (pin < PAM_PINS_PER_PORT)
		begin
			// Port A table
			return PAM_MAP_A[pin][code];
		end
		else
		begin
			// Port B table
			return PAM_MAP_B[pin-PAM_PINS_PER_PORT][code];
		end
	endfunction

	// Merges write data into a register under the APB byte strobes.
	// A clear strobe bit keeps the old byte.
	// Software can so change four pins at a time.
	// A byte holds whole fields, none is ever split.
	function automatic logic [31:0] pam_apply_strb(
		input logic [31:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0]  strb
	);
		logic [31:0] result;
		result = old_val;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				result[8*b +: 8] = wdata[8*b +: 8];
			end
		end
		return result;
	endfunction

	// The pad levels come from outside the clock domain, so they are synchronised first.
	// GPIO pins pass both stages too, so every
	// pin sees the same latency; the price is two
	// cycles on each input path.
	pam_sync #(
		.W(PAM_NUM_PINS)
	) u_pad_sync (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.async_i(pad_in_i),
		.sync_o (pad_sync)
	);

	// The slave never inserts wait states, so every access ends in its first access cycle.
	// The registers are plain flip-flops.
	// There is nothing to wait for, so a transfer
	// takes two cycles: setup, then one access.
	// A tied-high ready can never hang the bus.
	assign apb_access = psel_i & penable_i;
	assign pready_o   = 1'b1;

	// Address decode; low address bits must match too, so misaligned addresses miss.
	// Every address bit is compared, so nothing
	// aliases; a partial decode would be smaller
	// but would hide software address mistakes.
	assign hit_a = (paddr_i == PAM_PORT_A_SEL_OFS);
	assign hit_b = (paddr_i == PAM_PORT_B_SEL_OFS);

	// An unmapped address answers with an error in the access phase and changes nothing.
	// The error shows only while penable is high.
	// Write enables below need a hit as well,
	// so a refused write never lands.
	assign pslverr_o = apb_access & ~(hit_a | hit_b);

	// Read data mux; unmapped addresses and idle cycles read as zero.
	// The mux is combinational, so read data is
	// valid from the setup cycle on.
	// Gating with psel keeps the bus quiet.
	// Reads have no side effects.
	always_comb
	begin
		prdata_o = 32'h0000_0000;
		if (psel_i && hit_a)
		begin
			prdata_o = port_a_sel_reg;
		end
		else if (psel_i && hit_b)
		begin
			prdata_o = port_b_sel_reg;
		end
	end

	// Port A select register; byte strobes allow partial updates of the pin fields.
	// The write lands at the edge ending the
	// access cycle; the pad mux uses the new
	// fields from the next cycle on.
	// Reset makes every pin a GPIO pin.
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			port_a_sel_reg <= PAM_PORT_A_SEL_RST;
		end
		else if (apb_access && pwrite_i && hit_a)
		begin
			port_a_sel_reg <= pam_apply_strb(port_a_sel_reg, pwdata_i, pstrb_i);
		end
	end

	// Port B select register, same behaviour as port A.
	// Its fields cover pad bits 16 to 31.
	// Reset gives every port B pin to GPIO.
	// Strobes act exactly as for port A.
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			port_b_sel_reg <= PAM_PORT_B_SEL_RST;
		end
		else if (apb_access && pwrite_i && hit_b)
		begin
			port_b_sel_reg <= pam_apply_strb(port_b_sel_reg, pwdata_i, pstrb_i);
		end
	end

	// Output path to the pads. It is kept combinational from the select registers so a
	// peripheral's output reaches its pin without an added cycle, and so that a new
	// routing is on the pins in the cycle right after the write edge.
	// The price is a long path from the select
	// registers to the pads.
	// Each pin reads only its own field.
	// A released pin drives zero, enable low.
	// GPIO and peripheral drives share this clock,
	// so they need no synchroniser here.
	always_comb
	begin
		pam_sig_t sig;
		sig       = PAM_SIG_NONE;
		pad_out_o = '0;
		pad_oe_o  = '0;
		for (int i = 0; i < PAM_NUM_PINS; i++)
		begin
			sig = pam_pin_sig(port_a_sel_reg, port_b_sel_reg, i);
			if (pam_pin_code(port_a_sel_reg, port_b_sel_reg, i) == PAM_CODE_GPIO)
			begin
				// The GPIO logic owns the pin and its own settings govern it.
				pad_out_o[i] = gpio_out_i[i];
				pad_oe_o[i]  = gpio_oe_i[i];
			end
			else if (sig == PAM_SIG_NONE)
			begin
				// A code with no function leaves the pin released and unconnected.
				pad_out_o[i] = 1'b0;
				pad_oe_o[i]  = 1'b0;
			end
			else
			begin
				// The selected peripheral drives the pin; the GPIO logic is cut off.
				pad_out_o[i] = periph_out_i[sig];
				pad_oe_o[i]  = periph_oe_i[sig];
			end
		end
	end

	// Input path to GPIO logic and peripherals. A pin that is not in GPIO mode reads as
	// zero to the GPIO logic. When several pins select the same peripheral input, the
	// lowest pin number wins; software should avoid such double selection anyway.
	// The loop runs from the top pin down, so the
	// lowest pin's assignment is the one that stays.
	// Unfed inputs rest idle, so active-low
	// requests read as inactive.
	// Only synchronised pad levels are read here.
	always_comb
	begin
		pam_sig_t sig;
		sig             = PAM_SIG_NONE;
		gpio_in_next    = '0;
		gpio_owned_next = '0;
		periph_in_next  = PAM_SIG_IDLE;
		for (int i = PAM_NUM_PINS - 1; i >= 0; i--)
		begin
			sig = pam_pin_sig(port_a_sel_reg, port_b_sel_reg, i);
			if (pam_pin_code(port_a_sel_reg, port_b_sel_reg, i) == PAM_CODE_GPIO)
			begin
				gpio_in_next[i]    = pad_sync[i];
				gpio_owned_next[i] = 1'b1;
			end
			else if (sig != PAM_SIG_NONE)
			begin
				periph_in_next[sig] = pad_sync[i];
			end
		end
		// Identifier zero stands for no signal and always rests at its idle level.
		periph_in_next[PAM_SIG_NONE] = 1'b0;
	end

	// Input-side outputs come from flip-flops; they lag the pads by the two sync stages
	// plus this one, three cycles in all.
	// The register keeps the sync output off
	// long routes to the peripherals.
	// Ownership resets to all ones: every pin
	// starts as a GPIO pin.
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			gpio_in_reg    <= '0;
			gpio_owned_reg <= '1;
			periph_in_reg  <= PAM_SIG_IDLE;
		end
		else
		begin
			gpio_in_reg    <= gpio_in_next;
			gpio_owned_reg <= gpio_owned_next;
			periph_in_reg  <= periph_in_next;
		end
	end

	// Drive the registered views out.
	// No logic sits between these registers and
	// the ports. The GPIO logic may use
	// gpio_owned_o to ignore pins it does not own.
	assign gpio_in_o    = gpio_in_reg;
	assign gpio_owned_o = gpio_owned_reg;
	assign periph_in_o  = periph_in_reg;

endmodule

// ==== design/pam_pkg.sv ====
// Package with register map, signal identifiers and the pin routing table of the pin alternate-function mux.
package pam_pkg;

	// APB address width seen by the block and the register byte addresses.
	localparam int          PAM_ADDR_W        = 12;
	localparam logic [11:0] PAM_PORT_A_SEL_OFS = 12'h038;
	localparam logic [11:0] PAM_PORT_B_SEL_OFS = 12'h03C;

	// Reset values of the two select registers: every pin starts as general-purpose I/O.
	localparam logic [31:0] PAM_PORT_A_SEL_RST = 32'h0000_0000;
	localparam logic [31:0] PAM_PORT_B_SEL_RST = 32'h0000_0000;

	// Pin counts, select field layout and the general-purpose code.
	localparam int         PAM_PINS_PER_PORT = 16;
	localparam int         PAM_NUM_PINS      = 32;
	localparam int         PAM_FIELD_W       = 2;
	localparam logic [1:0] PAM_CODE_GPIO     = 2'h0;

	// Peripheral signal identifier; it indexes the peripheral-side port vectors.
	typedef logic [5:0] pam_sig_t;
	localparam int       PAM_NUM_SIG          = 40;
	localparam pam_sig_t PAM_SIG_NONE         = 6'h00;
	localparam pam_sig_t PAM_SIG_A0_TX        = 6'h01;
	localparam pam_sig_t PAM_SIG_A0_RX        = 6'h02;
	localparam pam_sig_t PAM_SIG_A0_RTS_N     = 6'h03;
	localparam pam_sig_t PAM_SIG_A0_CTS_N     = 6'h04;
	localparam pam_sig_t PAM_SIG_A1_TX        = 6'h05;
	localparam pam_sig_t PAM_SIG_A1_RX        = 6'h06;
	localparam pam_sig_t PAM_SIG_A1_CTS_N     = 6'h07;
	localparam pam_sig_t PAM_SIG_A1_HS_N      = 6'h08;
	localparam pam_sig_t PAM_SIG_LF_XTAL_OUT  = 6'h09;
	localparam pam_sig_t PAM_SIG_LF_XTAL_IN   = 6'h0A;
	localparam pam_sig_t PAM_SIG_MAIN_XTAL_OUT = 6'h0B;
	localparam pam_sig_t PAM_SIG_MAIN_XTAL_IN = 6'h0C;
	localparam pam_sig_t PAM_SIG_AUD_MCLK_OUT = 6'h0D;
	localparam pam_sig_t PAM_SIG_DIGITAL_MIC_CLOCK     = 6'h0E;
	localparam pam_sig_t PAM_SIG_DMIC_DATA    = 6'h0F;
	localparam pam_sig_t PAM_SIG_PWM0_CH0     = 6'h10;
	localparam pam_sig_t PAM_SIG_PWM0_CH1     = 6'h11;
	localparam pam_sig_t PAM_SIG_PWM0_CH2     = 6'h12;
	localparam pam_sig_t PAM_SIG_PWM0_CH3     = 6'h13;
	localparam pam_sig_t PAM_SIG_TMR0_EVT     = 6'h14;
	localparam pam_sig_t PAM_SIG_TMR1_EVT     = 6'h15;
	localparam pam_sig_t PAM_SIG_SPK_PLUS     = 6'h16;
	localparam pam_sig_t PAM_SIG_SPK_MINUS    = 6'h17;
	localparam pam_sig_t PAM_SIG_TW0_CLK      = 6'h18;
	localparam pam_sig_t PAM_SIG_TW0_DATA     = 6'h19;
	localparam pam_sig_t PAM_SIG_S1_DIN       = 6'h1A;
	localparam pam_sig_t PAM_SIG_S1_DOUT      = 6'h1B;
	localparam pam_sig_t PAM_SIG_S1_CLK       = 6'h1C;
	localparam pam_sig_t PAM_SIG_S1_SEL_N     = 6'h1D;
	localparam pam_sig_t PAM_SIG_S0_DOUT      = 6'h1E;
	localparam pam_sig_t PAM_SIG_S0_DOUT_ALT  = 6'h1F;
	localparam pam_sig_t PAM_SIG_S0_DIN_ALT   = 6'h20;
	localparam pam_sig_t PAM_SIG_S0_CLK       = 6'h21;
	localparam pam_sig_t PAM_SIG_S0_SEL_N     = 6'h22;
	localparam pam_sig_t PAM_SIG_ADC_TRIG     = 6'h23;
	localparam pam_sig_t PAM_SIG_AS0_DOUT     = 6'h24;
	localparam pam_sig_t PAM_SIG_AS0_DIN      = 6'h25;
	localparam pam_sig_t PAM_SIG_AS0_BCLK     = 6'h26;
	localparam pam_sig_t PAM_SIG_AS0_FSYNC    = 6'h27;

	// Level a peripheral input sees while no pin feeds it; active-low inputs idle high.
	localparam logic [39:0] PAM_SIG_IDLE = 40'h04_2000_0090;

	// Port A routing: one row per pin from pin 0, columns are codes 00, 01, 10, 11.
	localparam pam_sig_t PAM_MAP_A [16][4] = '{
		'{PAM_SIG_NONE, PAM_SIG_S0_DIN_ALT, PAM_SIG_NONE, PAM_SIG_AS0_FSYNC},
		'{PAM_SIG_NONE, PAM_SIG_S0_DOUT, PAM_SIG_NONE, PAM_SIG_AS0_BCLK},
		'{PAM_SIG_NONE, PAM_SIG_S0_CLK, PAM_SIG_DMIC_DATA, PAM_SIG_AS0_DIN},
		'{PAM_SIG_NONE, PAM_SIG_S0_SEL_N, PAM_SIG_ADC_TRIG, PAM_SIG_AS0_DOUT},
		'{PAM_SIG_NONE, PAM_SIG_NONE, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_S0_DOUT_ALT, PAM_SIG_A0_RX, PAM_SIG_S1_CLK},
		'{PAM_SIG_NONE, PAM_SIG_A0_TX, PAM_SIG_TW0_DATA, PAM_SIG_S1_SEL_N},
		'{PAM_SIG_NONE, PAM_SIG_A0_RX, PAM_SIG_TW0_CLK, PAM_SIG_S1_DIN},
		'{PAM_SIG_NONE, PAM_SIG_TW0_DATA, PAM_SIG_A1_TX, PAM_SIG_A0_RTS_N},
		'{PAM_SIG_NONE, PAM_SIG_TW0_CLK, PAM_SIG_A1_RX, PAM_SIG_A0_CTS_N},
		'{PAM_SIG_NONE, PAM_SIG_PWM0_CH0, PAM_SIG_TMR0_EVT, PAM_SIG_SPK_PLUS},
		'{PAM_SIG_NONE, PAM_SIG_PWM0_CH1, PAM_SIG_TMR1_EVT, PAM_SIG_SPK_MINUS},
		'{PAM_SIG_NONE, PAM_SIG_PWM0_CH2, PAM_SIG_MAIN_XTAL_IN, PAM_SIG_TW0_DATA},
		'{PAM_SIG_NONE, PAM_SIG_PWM0_CH3, PAM_SIG_MAIN_XTAL_OUT, PAM_SIG_TW0_CLK},
		'{PAM_SIG_NONE, PAM_SIG_A1_TX, PAM_SIG_DIGITAL_MIC_CLOCK, PAM_SIG_LF_XTAL_IN},
		'{PAM_SIG_NONE, PAM_SIG_A1_RX, PAM_SIG_AUD_MCLK_OUT, PAM_SIG_LF_XTAL_OUT}
	};

	// Port B routing, same layout as port A.
	localparam pam_sig_t PAM_MAP_B [16][4] = '{
		'{PAM_SIG_NONE, PAM_SIG_S1_DOUT, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_S1_CLK, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_S1_SEL_N, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_S1_DIN, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_AS0_FSYNC, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_AS0_BCLK, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_AS0_DIN, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_AS0_DOUT, PAM_SIG_NONE, PAM_SIG_NONE},
		'{PAM_SIG_NONE, PAM_SIG_TW0_DATA, PAM_SIG_AS0_FSYNC, PAM_SIG_A1_HS_N},
		'{PAM_SIG_NONE, PAM_SIG_TW0_CLK, PAM_SIG_AS0_BCLK, PAM_SIG_A1_CTS_N},
		'{PAM_SIG_NONE, PAM_SIG_NONE, PAM_SIG_AS0_DIN, PAM_SIG_A1_TX},
		'{PAM_SIG_NONE, PAM_SIG_NONE, PAM_SIG_AS0_DOUT, PAM_SIG_A1_RX},
		'{PAM_SIG_NONE, PAM_SIG_S0_DIN_ALT, PAM_SIG_S1_DOUT, PAM_SIG_DMIC_DATA},
		'{PAM_SIG_NONE, PAM_SIG_S0_DOUT, PAM_SIG_S1_CLK, PAM_SIG_ADC_TRIG},
		'{PAM_SIG_NONE, PAM_SIG_S0_CLK, PAM_SIG_S1_SEL_N, PAM_SIG_DIGITAL_MIC_CLOCK},
		'{PAM_SIG_NONE, PAM_SIG_S0_SEL_N, PAM_SIG_S1_DIN, PAM_SIG_AUD_MCLK_OUT}
	};

endpackage

// ==== design/pam_sync.sv ====
// Two-flop synchroniser for a vector of pad levels.
`timescale 1ns/1ps

module pam_sync #(
	parameter int W = 32
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	// Asynchronous levels in, synchronised levels out.
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	// First stage may go metastable; only the second stage reads it.
	logic [W-1:0] sync_meta_reg;
	// Second stage, the only output of this module.
	logic [W-1:0] sync_out_reg;

	// Both stages clear to zero under reset.
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync_meta_reg <= '0;
			sync_out_reg  <= '0;
		end
		else
		begin
			sync_meta_reg <= async_i;
			sync_out_reg  <= sync_meta_reg;
		end
	end

	assign sync_o = sync_out_reg;

endmodule

// ==== verification/pam_pin_mux_properties.sv ====
// Concurrent checks on the ports of the pin alternate-function mux.
`timescale 1ns/1ps

module pam_pin_mux_properties
	import pam_pkg::*;
(
	// Clock and reset.
	input  wire logic                             clk_i,
	input  wire logic                             rstn_i,
	// APB slave port.
	input  wire logic                             psel_i,
	input  wire logic                             penable_i,
	input  wire logic                             pwrite_i,
	input  wire logic [pam_pkg::PAM_ADDR_W-1:0]   paddr_i,
	input  wire logic [31:0]                      prdata_o,
	input  wire logic                             pready_o,
	input  wire logic                             pslverr_o,
	// Pads and GPIO side.
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] pad_in_i,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] pad_out_o,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] pad_oe_o,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_out_i,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_oe_i,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_in_o,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] gpio_owned_o,
	// Peripheral side.
	input  wire logic [pam_pkg::PAM_NUM_SIG-1:0]  periph_in_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// Edges since reset release, saturating; synchroniser history is not valid before three.
	logic [1:0] up_cnt;
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			up_cnt <= 2'h0;
		else if (up_cnt != 2'h3)
			up_cnt <= up_cnt + 2'h1;
	end

	// Access phase and register hit decode.
	logic acc;
	logic hit;
	assign acc = psel_i && penable_i;
	assign hit = (paddr_i == PAM_PORT_A_SEL_OFS) || (paddr_i == PAM_PORT_B_SEL_OFS);

	property p_ready;
		acc |-> pready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low in access phase");

	property p_unmapped;
		acc && !hit |-> pslverr_o && (prdata_o == 32'h0000_0000);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

	property p_mapped;
		acc && hit |-> !pslverr_o;
	endproperty
	a_mapped: assert property (p_mapped) else $error("select register access refused");

	property p_excl;
		(gpio_in_o & ~gpio_owned_o) == 32'h0000_0000;
	endproperty
	a_excl: assert property (p_excl) else $error("GPIO sees a pin it does not own");

	// Owned in two successive cycles means the select field was 00 in the earlier one.
	property p_gpio_drive;
		((($past(pad_oe_o) ^ $past(gpio_oe_i)) | ($past(pad_out_o) ^ $past(gpio_out_i)))
			& gpio_owned_o & $past(gpio_owned_o)) == 32'h0000_0000;
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("GPIO pin pad not driven by GPIO");

	property p_gpio_in;
		up_cnt == 2'h3 |-> gpio_in_o == (gpio_owned_o & $past(pad_in_i, 3));
	endproperty
	a_gpio_in: assert property (p_gpio_in) else $error("GPIO input level or latency wrong");

	property p_owner_moves;
		$changed(gpio_owned_o) |-> $past(psel_i, 2) && $past(penable_i, 2) && $past(pwrite_i, 2);
	endproperty
	a_owner_moves: assert property (p_owner_moves) else $error("ownership changed without a write");

	property p_idle0;
		periph_in_o[0] == 1'b0;
	endproperty
	a_idle0: assert property (p_idle0) else $error("unused peripheral input driven");
endmodule

// ==== verification/pam_pad_model.sv ====
// Pad environment: resolves each pad from the mux drive, an outside driver and a floating level.
`timescale 1ns/1ps

module pam_pad_model
	import pam_pkg::*;
(
	// Clock.
	input  wire logic                             clk_i,
	// Mux drive of the pads.
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] pad_out_i,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] pad_oe_i,
	// Outside driver, active while ext_en_i is high.
	input  wire logic                             ext_en_i,
	input  wire logic [pam_pkg::PAM_NUM_PINS-1:0] ext_i,
	// Resolved pad levels back to the mux.
	output logic      [pam_pkg::PAM_NUM_PINS-1:0] pad_in_o
);
	// An undriven pad toggles each cycle, so a stale level never passes for a real one.
	logic [PAM_NUM_PINS-1:0] flt_reg = 32'h5555_5555;
	always_ff @(posedge clk_i)
		flt_reg <= ~flt_reg;
	assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & (ext_en_i ? ext_i : flt_reg));
endmodule

// ==== verification/tb_pam_pin_mux.sv ====
// Self-checking bench for the pin alternate-function mux.
`timescale 1ns/1ps
`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("ERROR %0t got %0h exp %0h", $time, g, e); \
		end \
	end

module tb_pam_pin_mux;
	import pam_pkg::*;
	logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, ext_en;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, pad_in_i, pad_out_o, pad_oe_o, gpio_out_i, gpio_oe_i, gpio_in_o, gpio_owned_o, ext;
	logic [3:0]  pstrb_i;
	logic [39:0] periph_out_i, periph_oe_i, periph_in_o;
	int          n_mismatch = 0;
	int          tests_run = 0;
	// Peripheral id per pin (A0..A15, B0..B15) for codes 01, 10, 11, one byte each.
	localparam logic [23:0] MAP [32] = '{24'h200027, 24'h1E0026, 24'h210F25, 24'h222324, 24'h000000,
		24'h1F021C, 24'h01191D, 24'h02181A, 24'h190503, 24'h180604, 24'h101416, 24'h111517, 24'h120C19,
		24'h130B18, 24'h050E0A, 24'h060D09, 24'h1B0000, 24'h1C0000, 24'h1D0000, 24'h1A0000, 24'h270000,
		24'h260000, 24'h250000, 24'h240000, 24'h192708, 24'h182607, 24'h002505, 24'h002406, 24'h201B0F,
		24'h1E1C23, 24'h211D0E, 24'h221A0D};

	pam_pin_mux uut (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
		.prdata_o, .pready_o, .pslverr_o, .pad_in_i, .pad_out_o, .pad_oe_o, .gpio_out_i, .gpio_oe_i,
		.gpio_in_o, .gpio_owned_o, .periph_out_i, .periph_oe_i, .periph_in_o);
	pam_pad_model u_pads (.clk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_en_i(ext_en),
		.ext_i(ext), .pad_in_o(pad_in_i));

	// One APB transfer; the request is held until pready is seen at a rising edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
			@(posedge clk_i);
		while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Reset state: registers zero, every pad owned by GPIO.
	task automatic t_reset();
		logic [31:0] rd;
		logic        err;
		gpio_out_i <= 32'hC3A5_0F96;
		gpio_oe_i <= 32'hFF00_F0F0;
		ext_en <= 1'b1;
		ext <= 32'h6B2D_91E4;
		repeat (4) @(posedge clk_i);
		#1;
		`CHK(pad_out_o, 32'hC3A5_0F96)
		`CHK(pad_oe_o, 32'hFF00_F0F0)
		`CHK(gpio_in_o, 32'hC32D_0194)
		`CHK(gpio_owned_o, 32'hFFFF_FFFF)
		`CHK(periph_in_o, PAM_SIG_IDLE)
		apb(1'b0, PAM_PORT_A_SEL_OFS, 32'h0, 4'h0, rd, err);
		`CHK(rd, 32'h0000_0000)
		apb(1'b0, PAM_PORT_B_SEL_OFS, 32'h0, 4'h0, rd, err);
		`CHK(rd, 32'h0000_0000)
		$display("t_reset done");
	endtask

	// Readback, byte strobes and refused addresses.
	task automatic t_regs();
		logic [31:0] rd;
		logic        err;
		apb(1'b1, PAM_PORT_A_SEL_OFS, 32'hA5A5_5A5A, 4'hF, rd, err);
		apb(1'b1, PAM_PORT_B_SEL_OFS, 32'h1234_5678, 4'h5, rd, err);
		apb(1'b1, 12'h040, 32'hFFFF_FFFF, 4'hF, rd, err);
		`CHK(err, 1'b1)
		apb(1'b1, 12'h039, 32'hFFFF_FFFF, 4'hF, rd, err);
		`CHK(err, 1'b1)
		apb(1'b0, PAM_PORT_A_SEL_OFS, 32'h0, 4'h0, rd, err);
		`CHK(rd, 32'hA5A5_5A5A)
		apb(1'b0, PAM_PORT_B_SEL_OFS, 32'h0, 4'h0, rd, err);
		`CHK(rd, 32'h0034_0078)
		$display("t_regs done");
	endtask

	// Every pin and code: output drive, release and input routing.
	task automatic t_route();
		logic [31:0] rd, sel, bp;
		logic        err, lv;
		logic [5:0]  id;
		logic [39:0] oh;
		for (int p = 0; p < 32; p++)
		begin
			for (int c = 1; c < 4; c++)
			begin
				@(posedge clk_i);
				id = MAP[p][8*(3-c) +: 6];
				oh = 40'h1 << id;
				bp = 32'h1 << p;
				sel = 32'(c) << (2 * (p % 16));
				lv = ~PAM_SIG_IDLE[id];
				periph_out_i <= oh;
				periph_oe_i <= oh;
				gpio_out_i <= 32'hFFFF_FFFF;
				gpio_oe_i <= 32'hFFFF_FFFF;
				ext_en <= 1'b0;
				apb(1'b1, PAM_PORT_A_SEL_OFS, (p < 16) ? sel : 32'h0, 4'hF, rd, err);
				apb(1'b1, PAM_PORT_B_SEL_OFS, (p < 16) ? 32'h0 : sel, 4'hF, rd, err);
				#1;
				`CHK(pad_out_o[p], id != 6'h0)
				`CHK(pad_oe_o, (id != 6'h0) ? 32'hFFFF_FFFF : ~bp)
				@(posedge clk_i);
				periph_out_i <= ~oh;
				gpio_out_i <= 32'h0;
				gpio_oe_i <= 32'h0;
				#1;
				`CHK(pad_out_o, 32'h0)
				`CHK(pad_oe_o, (id != 6'h0) ? bp : 32'h0)
				@(posedge clk_i);
				periph_oe_i <= 40'h0;
				ext_en <= 1'b1;
				ext <= {32{lv}};
				repeat (4) @(posedge clk_i);
				#1;
				`CHK(periph_in_o, (id != 6'h0) ? ((PAM_SIG_IDLE & ~oh) | ({40{lv}} & oh)) : PAM_SIG_IDLE)
				`CHK(gpio_in_o, {32{lv}} & ~bp)
				`CHK(gpio_owned_o, ~bp)
			end
		end
		$display("t_route done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Clock at 250 MHz.
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Main sequence, all inputs defined at time zero.
	initial
	begin
		rstn_i = 1'b0;
		{psel_i, penable_i, pwrite_i, ext_en} = 4'h0;
		{paddr_i, pwdata_i, pstrb_i, ext, gpio_out_i, gpio_oe_i} = 0;
		{periph_out_i, periph_oe_i} = 80'h0;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_regs();
		t_route();
		wrap_up();
	end

	// Watchdog, well beyond the roughly 1300 cycles the tests need.
	initial
	begin
		#200000;
		n_mismatch++;
		wrap_up();
	end
endmodule

bind pam_pin_mux pam_pin_mux_properties u_props (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.prdata_o, .pready_o, .pslverr_o, .pad_in_i, .pad_out_o, .pad_oe_o, .gpio_out_i, .gpio_oe_i, .gpio_in_o,
	.gpio_owned_o, .periph_in_o);
